// >>> rtl/adcsr_pkg.sv
// Constants shared by the converter configuration register bank.
package adcsr_pkg;

    // Register count and the byte address of each storage slot.
    localparam int ADCSR_NREG = 15;
    localparam logic [7:0] ADCSR_ADDR [0:ADCSR_NREG-1] = '{
        8'h00, 8'h01, 8'h03, 8'h25, 8'h26, 8'h3d, 8'h3f, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h4a, 8'hbf, 8'hcf, 8'hdf
    };

    // Storage index of each register that the logic uses.
    localparam logic [3:0] IDX_RESET_AND_READBACK_CTRL = 4'h0;
    localparam logic [3:0] IDX_OUTPUT_SWING_SELECT = 4'h1;
    localparam logic [3:0] IDX_PERFORMANCE_MODE_ONE = 4'h2;
    localparam logic [3:0] IDX_GAIN_AND_TEST_PATTERN = 4'h3;
    localparam logic [3:0] IDX_OUTPUT_DRIVE_STRENGTH = 4'h4;
    localparam logic [3:0] IDX_FORMAT_AND_OFFSET_ENABLE = 4'h5;
    localparam logic [3:0] IDX_CUSTOM_WORD_HIGH = 4'h6;
    localparam logic [3:0] IDX_CUSTOM_WORD_LOW = 4'h7;
    localparam logic [3:0] IDX_CLOCK_FALL_AND_STANDBY = 4'h9;
    localparam logic [3:0] IDX_POWER_DOWN_AND_SWING_ENABLE = 4'ha;
    localparam logic [3:0] IDX_PERFORMANCE_MODE_TWO = 4'hb;

    // Reset value of every register.
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // Field positions.
    localparam int SOFT_RESET_BIT = 1;
    localparam int READBACK_BIT = 0;
    localparam int SWING_MSB = 7;
    localparam int SWING_LSB = 2;
    localparam int SWING_EN_MSB = 1;
    localparam int SWING_EN_LSB = 0;
    localparam int GAIN_MSB = 7;
    localparam int GAIN_LSB = 4;
    localparam int GAIN_DISABLE_BIT = 3;
    localparam int PATTERN_MSB = 2;
    localparam int PATTERN_LSB = 0;
    localparam int CLK_DRIVE_BIT = 1;
    localparam int DATA_DRIVE_BIT = 0;
    localparam int FORMAT_MSB = 7;
    localparam int FORMAT_LSB = 6;
    localparam int OFFSET_FIX_BIT = 5;
    localparam int DIGITAL_PATH_BIT = 3;

    // Field codes.
    localparam logic [5:0] SWING_DEFAULT = 6'h00;
    localparam logic [1:0] SWING_EN_ON = 2'h3;
    localparam logic [1:0] FORMAT_FROM_PIN = 2'h0;
    localparam logic [1:0] FORMAT_TWOS = 2'h2;
    localparam logic [1:0] FORMAT_OFFSET = 2'h3;
    localparam logic [3:0] GAIN_NONE = 4'h0;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [2:0] PAT_RAMP = 3'h4;
    localparam logic [2:0] PAT_CUSTOM = 3'h5;
    localparam logic [11:0] TOGGLE_WORD = 12'h555;

    // Serial frame: last bit index of the address byte and of the whole frame.
    localparam logic [3:0] FRAME_ADDR_LAST = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    // Last divider count of a ramp step; four samples per step.
    localparam logic [1:0] RAMP_STEP_LAST = 2'h3;

endpackage : adcsr_pkg

// >>> rtl/adcsr_regbank.sv
// Serial-programmed configuration register bank and digital output path.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Reset bit clears all registers, self-clears.
// - Readback bit routes readback onto over-range pin.
// - Swing field selects differential output swing.
// - Programmed swing applies only when enabled.
// - Gain field selects 0.5 dB steps.
// - Gain applied only if enabled, path on.
// - Pattern 000 normal, 001 zeros, 010 ones.
// - Pattern 011 alternates 0101 and 1010 words.
// - Pattern 100 ramps every fourth sample.
// - Pattern 101 outputs custom twelve-bit word.
// - Clock buffer drive bit doubles strength.
// - Data buffer drive bit doubles strength.
// - Format field: pin, two's complement, offset.
// - Offset fix enable bit.
// - Every register resets to 00h.
// - One write updates all fields together.
// - Sixteen-bit frames on falling edges, address first.
// - Readback blocks writes except address zero.
// - Low-latency mode bypasses gain, patterns, offset.
// - Swing enable only at code 11.
module adcsr_regbank
    import adcsr_pkg::*;
#(
    parameter int DATA_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serial_select_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic overvoltage_in,
    input wire logic format_select_pin,
    input wire logic sample_strobe,
    input wire logic [DATA_W-1:0] adc_code,
    output logic overrange_or_readback_pin,
    output logic [5:0] swing_code,
    output logic clock_buffer_drive,
    output logic data_buffer_drive,
    output logic [1:0] performance_boost_one,
    output logic performance_boost_two,
    output logic [3:0] gain_select,
    output logic offset_fix_enable,
    output logic digital_path_enable,
    output logic twos_complement,
    output logic [DATA_W-1:0] data_out_reg
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Maps an address to its storage slot; valid is low for unlisted addresses.
    function automatic logic [4:0] addr_lookup(input logic [7:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < ADCSR_NREG; i++) begin
            if (ADCSR_ADDR[i] == addr) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : addr_lookup

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second.

    logic [1:0] cs_sync_reg;
    logic [1:0] sin_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [1:0] ovr_sync_reg;
    logic [1:0] fmt_sync_reg;

    // Two flops per pin, a third on the serial clock for edge finding.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 2'h3;
            sin_sync_reg <= 2'h0;
            sclk_sync_reg <= 3'h0;
            ovr_sync_reg <= 2'h0;
            fmt_sync_reg <= 2'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], serial_select_n};
            sin_sync_reg <= {sin_sync_reg[0], serial_in};
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
            ovr_sync_reg <= {ovr_sync_reg[0], overvoltage_in};
            fmt_sync_reg <= {fmt_sync_reg[0], format_select_pin};
        end
    end

    logic sel_active;
    logic sclk_fall;
    logic sin_bit;
    assign sel_active = !cs_sync_reg[1];
    assign sin_bit = sin_sync_reg[1];
    // The serial clock must stay well below half the system rate to be sampled.
    assign sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1] && sel_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame shifter.

    logic [3:0] bit_cnt_reg;
    logic [14:0] shift_reg;
    logic [7:0] rd_shift_reg;
    logic [7:0] regs_reg [0:ADCSR_NREG-1];

    logic [7:0] frame_addr;
    logic [7:0] frame_data;
    logic [7:0] rd_addr;
    logic [4:0] wr_hit;
    logic [4:0] rd_hit;
    logic readback_on;
    logic write_fire;
    logic soft_reset;

    assign frame_addr = shift_reg[14:7];
    assign frame_data = {shift_reg[6:0], sin_bit};
    assign rd_addr = {shift_reg[6:0], sin_bit};
    assign wr_hit = addr_lookup(frame_addr);
    assign rd_hit = addr_lookup(rd_addr);
    assign readback_on = regs_reg[IDX_RESET_AND_READBACK_CTRL][READBACK_BIT];
    // Every sixteenth falling edge loads a word; partial words are dropped.
    assign write_fire = sclk_fall && (bit_cnt_reg == FRAME_LAST);
    assign soft_reset = write_fire && (frame_addr == ADCSR_ADDR[0])
        && frame_data[SOFT_RESET_BIT];

    // Bit counter restarts whenever the select is released.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 15'h0000;
        end else if (!sel_active) begin
            bit_cnt_reg <= 4'h0;
        end else if (sclk_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= {shift_reg[13:0], sin_bit};
        end
    end

    // Readback shifter: loaded after the address byte, shifted on later edges.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_shift_reg <= 8'h00;
        end else if (sclk_fall && bit_cnt_reg == FRAME_ADDR_LAST) begin
            // Slot zero is never readable; unlisted addresses answer zero.
            if (rd_hit[4] && rd_hit[3:0] != IDX_RESET_AND_READBACK_CTRL) begin
                rd_shift_reg <= regs_reg[rd_hit[3:0]];
            end else begin
                rd_shift_reg <= 8'h00;
            end
        end else if (sclk_fall) begin
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage.

    // Whole bytes are stored, so all fields of a register change in one write.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ADCSR_NREG; i++) begin
                regs_reg[i] <= REG_RESET_VALUE;
            end
        end else if (soft_reset) begin
            // The reset bit itself is never stored, so it reads back as zero.
            for (int i = 0; i < ADCSR_NREG; i++) begin
                regs_reg[i] <= REG_RESET_VALUE;
            end
        end else if (write_fire && wr_hit[4]) begin
            if (!readback_on || wr_hit[3:0] == IDX_RESET_AND_READBACK_CTRL) begin
                regs_reg[wr_hit[3:0]] <= frame_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared pin and analog settings.

    logic [7:0] r_swing;
    logic [7:0] r_gain;
    logic [7:0] r_drive;
    logic [7:0] r_fmt;
    logic [7:0] r_pdn;
    logic [1:0] fmt_field;
    logic [2:0] pattern;

    assign r_swing = regs_reg[IDX_OUTPUT_SWING_SELECT];
    assign r_gain = regs_reg[IDX_GAIN_AND_TEST_PATTERN];
    assign r_drive = regs_reg[IDX_OUTPUT_DRIVE_STRENGTH];
    assign r_fmt = regs_reg[IDX_FORMAT_AND_OFFSET_ENABLE];
    assign r_pdn = regs_reg[IDX_POWER_DOWN_AND_SWING_ENABLE];
    assign fmt_field = r_fmt[FORMAT_MSB:FORMAT_LSB];
    assign pattern = r_gain[PATTERN_MSB:PATTERN_LSB];

    // The pin shows readback bits only in readback mode.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            overrange_or_readback_pin <= 1'b0;
        end else if (readback_on) begin
            overrange_or_readback_pin <= rd_shift_reg[7];
        end else begin
            overrange_or_readback_pin <= ovr_sync_reg[1];
        end
    end

    // Static settings, registered so each output is glitch free.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            swing_code <= SWING_DEFAULT;
            clock_buffer_drive <= 1'b0;
            data_buffer_drive <= 1'b0;
            performance_boost_one <= 2'h0;
            performance_boost_two <= 1'b0;
            gain_select <= GAIN_NONE;
            offset_fix_enable <= 1'b0;
            digital_path_enable <= 1'b0;
            twos_complement <= 1'b0;
        end else begin
            // Codes 01 and 10 of the enable leave the default swing.
            if (r_pdn[SWING_EN_MSB:SWING_EN_LSB] == SWING_EN_ON) begin
                swing_code <= r_swing[SWING_MSB:SWING_LSB];
            end else begin
                swing_code <= SWING_DEFAULT;
            end
            clock_buffer_drive <= r_drive[CLK_DRIVE_BIT];
            data_buffer_drive <= r_drive[DATA_DRIVE_BIT];
            performance_boost_one <= regs_reg[IDX_PERFORMANCE_MODE_ONE][1:0];
            performance_boost_two <= regs_reg[IDX_PERFORMANCE_MODE_TWO][0];
            digital_path_enable <= regs_reg[IDX_CLOCK_FALL_AND_STANDBY][DIGITAL_PATH_BIT];
            if (digital_path_enable && !r_gain[GAIN_DISABLE_BIT]) begin
                gain_select <= r_gain[GAIN_MSB:GAIN_LSB];
            end else begin
                gain_select <= GAIN_NONE;
            end
            offset_fix_enable <= r_fmt[OFFSET_FIX_BIT] && digital_path_enable;
            // Code 01 is undefined; it falls back to the pin like 00.
            case (fmt_field)
                FORMAT_TWOS: twos_complement <= 1'b1;
                FORMAT_OFFSET: twos_complement <= 1'b0;
                default: twos_complement <= fmt_sync_reg[1];
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample data path and test patterns.

    logic toggle_reg;
    logic [1:0] ramp_div_reg;
    logic [DATA_W-1:0] ramp_reg;
    logic [DATA_W-1:0] custom_word;

    assign custom_word = DATA_W'({regs_reg[IDX_CUSTOM_WORD_HIGH],
        regs_reg[IDX_CUSTOM_WORD_LOW][7:4]});

    // Pattern sequencers advance on each sample; the ramp wraps after full scale.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            toggle_reg <= 1'b0;
            ramp_div_reg <= 2'h0;
            ramp_reg <= '0;
        end else if (sample_strobe) begin
            toggle_reg <= !toggle_reg;
            ramp_div_reg <= ramp_div_reg + 2'h1;
            if (ramp_div_reg == RAMP_STEP_LAST) begin
                ramp_reg <= ramp_reg + DATA_W'(1);
            end
        end
    end

    // Output word; low-latency mode passes the converter code, MSB inverted for two's complement.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_out_reg <= '0;
        end else if (sample_strobe) begin
            if (!digital_path_enable || pattern == PAT_NORMAL) begin
                data_out_reg <= twos_complement ? {~adc_code[DATA_W-1],
                    adc_code[DATA_W-2:0]} : adc_code;
            end else begin
                case (pattern)
                    PAT_ZEROS: data_out_reg <= '0;
                    PAT_ONES: data_out_reg <= '1;
                    PAT_TOGGLE: data_out_reg <= toggle_reg ? ~DATA_W'(TOGGLE_WORD)
                        : DATA_W'(TOGGLE_WORD);
                    PAT_RAMP: data_out_reg <= ramp_reg;
                    PAT_CUSTOM: data_out_reg <= custom_word;
                    default: data_out_reg <= '0;
                endcase
            end
        end
    end

endmodule : adcsr_regbank

`default_nettype wire

// >>> verif/adcsr_props.sv
// Concurrent checks on the output ports of the configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module adcsr_props #(
    parameter int DATA_W = 12
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic serial_select_n,
    input wire logic format_select_pin,
    input wire logic sample_strobe,
    input wire logic [DATA_W-1:0] adc_code,
    input wire logic [5:0] swing_code,
    input wire logic clock_buffer_drive,
    input wire logic data_buffer_drive,
    input wire logic [1:0] performance_boost_one,
    input wire logic [3:0] gain_select,
    input wire logic offset_fix_enable,
    input wire logic digital_path_enable,
    input wire logic twos_complement,
    input wire logic [DATA_W-1:0] data_out_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [3:0] idle_reg;

    // Counts deselected cycles; it saturates so that long idle spans stay legal.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= 4'h0;
        end else if (!serial_select_n) begin
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hf) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_reset_clears_all: assert property (
        $rose(rst_n) |-> {swing_code, gain_select, offset_fix_enable, data_out_reg} == '0)
        else $error("outputs not clear after reset");
    a_gain_needs_path: assert property (
        gain_select != 4'h0 |-> $past(digital_path_enable))
        else $error("gain applied with the digital path off");
    a_offset_needs_path: assert property (
        offset_fix_enable |-> $past(digital_path_enable))
        else $error("offset fix enabled with the digital path off");
    a_path_drop_clears: assert property (
        $fell(digital_path_enable) |=> gain_select == 4'h0 && !offset_fix_enable)
        else $error("digital functions still on after path drop");
    a_data_holds: assert property (
        !$past(sample_strobe) |-> $stable(data_out_reg))
        else $error("output word moved without a sample");
    a_bypass_passes_code: assert property (
        $past(sample_strobe) && !$past(digital_path_enable) |->
        data_out_reg == ($past(adc_code) ^ {$past(twos_complement), {(DATA_W-1){1'b0}}}))
        else $error("bypassed word differs from the converter code");
    a_settings_idle_frozen: assert property (
        idle_reg >= 4'd8 |-> $stable({swing_code, clock_buffer_drive, data_buffer_drive,
        performance_boost_one, gain_select}))
        else $error("setting changed with no serial frame");
    a_format_settles: assert property (
        $stable(format_select_pin) [*6] ##0 idle_reg >= 4'd14 |=> $stable(twos_complement))
        else $error("format moved with steady pin and registers");

    // Main scenarios that the bench is expected to reach.
    c_strobe_path_on: cover property (sample_strobe && digital_path_enable);
    c_gain_max: cover property (gain_select == 4'hc);
    c_swing_low: cover property (swing_code == 6'h3e);
    c_path_drop: cover property ($fell(digital_path_enable));
endmodule : adcsr_props
bind adcsr_regbank adcsr_props #(.DATA_W(DATA_W)) u_props (.*);
`default_nettype wire

// >>> verif/adcsr_ctrl_model.sv
// Behavioural model of the controller on the three-wire serial port.
`timescale 1ns/10ps
`default_nettype none
module adcsr_ctrl_model (
    input wire logic clk_sys,
    input wire logic overrange_or_readback_pin,
    output var logic serial_select_n,
    output var logic sclk,
    output var logic serial_in
);
    // Phase length in system clocks; four gives the 200 ns serial period.
    int ph = 4;

    // The serial clock stands low between frames.
    initial begin
        serial_select_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    // One word, address first; data changes while the clock is high, so it is
    // steady at the falling edge, and readback is sampled just before that edge.
    task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {a, d};
        serial_select_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (ph) @(posedge clk_sys);
            sclk <= 1'b1;
            serial_in <= w[i];
            repeat (ph) @(posedge clk_sys);
            if (i < 8) begin
                q[i] = overrange_or_readback_pin;
            end
            sclk <= 1'b0;
        end
        repeat (8) @(posedge clk_sys);
        serial_select_n <= 1'b1;
        serial_in <= ~w[0]; // Released line must not keep showing the last bit.
    endtask : frame
endmodule : adcsr_ctrl_model
`default_nettype wire

// >>> verif/adcsr_regbank_tb_top.sv
// Self-checking bench for the serial configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module adcsr_regbank_tb_top;
    import adcsr_pkg::*;
    logic clk_sys, rst_n, serial_select_n, sclk, serial_in, overvoltage_in;
    logic format_select_pin, sample_strobe, overrange_or_readback_pin, clock_buffer_drive;
    logic data_buffer_drive, performance_boost_two, offset_fix_enable, digital_path_enable;
    logic twos_complement;
    logic [11:0] adc_code, data_out_reg, cw, x, got;
    logic [11:0] v [8];
    logic [5:0] swing_code;
    logic [1:0] performance_boost_one;
    logic [3:0] gain_select;
    logic [7:0] q;
    logic [31:0] seed = 32'h2ff51704;
    logic [5:0] swing_tab [6] = '{6'h00, 6'h1b, 6'h32, 6'h14, 6'h3e, 6'h0f};
    int bad_count = 0;
    int n_compared = 0;

    adcsr_regbank #(.DATA_W(12)) u_dut (.*);
    adcsr_ctrl_model u_ctl (.*);

    // Free-running 40 MHz system clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [11:0] exp_pat(input logic [2:0] p, input logic [11:0] c,
                                            input logic [11:0] w);
        case (p)
            PAT_NORMAL: return c;
            PAT_ONES: return 12'hfff;
            PAT_CUSTOM: return w;
            default: return 12'h000;
        endcase
    endfunction : exp_pat

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_ctl.frame(a, d, q);
        repeat (4) @(posedge clk_sys);
    endtask : wr

    // One random sample; the word is read off the edge so no race is possible.
    task automatic smp(output logic [11:0] r);
        seed = lfsr(seed);
        x = seed[11:0];
        sample_strobe <= 1'b1;
        adc_code <= x;
        @(posedge clk_sys);
        sample_strobe <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 r = data_out_reg;
        @(posedge clk_sys);
    endtask : smp

    task automatic grab;
        for (int i = 0; i < 8; i++) begin
            smp(v[i]);
        end
    endtask : grab

    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // A hang stops the run well beyond the few thousand cycles the tests need.
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        $display("Error watchdog expected done seen hang");
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence; fixed-zero bits are always written as zero.
    initial begin
        rst_n = 1'b0;
        sample_strobe = 1'b0;
        adc_code = 12'h000;
        overvoltage_in = 1'b0;
        format_select_pin = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("reset", 12'h000, {swing_code, gain_select, offset_fix_enable, digital_path_enable});
        $display("Test reset done");
        foreach (swing_tab[i]) begin
            wr(8'h01, {swing_tab[i], 2'b00});
            wr(8'h43, 8'h00);
            chk("swing_off", 12'h000, {6'h00, swing_code});
            wr(8'h43, 8'h03);
            chk("swing_on", {6'h00, swing_tab[i]}, {6'h00, swing_code});
        end
        for (int d = 0; d < 4; d++) begin
            wr(8'h26, 8'(d));
            chk("drive", 12'(d), {10'h0, clock_buffer_drive, data_buffer_drive});
        end
        wr(8'h03, 8'h03);
        wr(8'h4a, 8'h01);
        chk("boost", 12'h007, {9'h0, performance_boost_one, performance_boost_two});
        $display("Test settings done");
        wr(8'h25, 8'hc0);
        chk("gain_bypass", 12'h000, {8'h0, gain_select});
        wr(8'h42, 8'h08);
        chk("gain_on", 12'h00c, {8'h0, gain_select});
        wr(8'h25, 8'hc8);
        chk("gain_off", 12'h000, {8'h0, gain_select});
        wr(8'h3d, 8'ha0);
        chk("format_two", 12'h003, {10'h0, twos_complement, offset_fix_enable});
        wr(8'h3d, 8'hc0);
        chk("format_bin", 12'h000, {10'h0, twos_complement, offset_fix_enable});
        format_select_pin <= 1'b1;
        wr(8'h3d, 8'h00);
        chk("format_pin", 12'h002, {10'h0, twos_complement, offset_fix_enable});
        wr(8'h3d, 8'h40);
        chk("format_rsv", 12'h002, {10'h0, twos_complement, offset_fix_enable});
        $display("Test gain and format done");
        wr(8'h3d, 8'hc0);
        seed = lfsr(seed);
        cw = seed[23:12];
        wr(8'h3f, cw[11:4]);
        wr(8'h40, {cw[3:0], 4'h0});
        for (int p = 0; p < 8; p++) begin
            if (p != 3 && p != 4) begin
                wr(8'h25, 8'(p));
                smp(got);
                chk("pattern", exp_pat(3'(p), x, cw), got);
            end
        end
        wr(8'h25, 8'h03);
        grab();
        chk("toggle_word", 12'h555, v[0][0] ? v[0] : v[1]);
        for (int i = 0; i < 7; i++) begin
            chk("toggle", ~v[i], v[i+1]);
        end
        wr(8'h25, 8'h04);
        grab();
        for (int i = 0; i < 4; i++) begin
            chk("ramp", v[i] + 12'h001, v[i+4]);
        end
        wr(8'h42, 8'h00);
        wr(8'h25, 8'h01);
        smp(got);
        chk("bypass", x, got);
        wr(8'h3d, 8'h80);
        smp(got);
        chk("twos", x ^ 12'h800, got);
        $display("Test patterns done");
        wr(8'h02, 8'h77);
        wr(8'h3f, 8'h5a);
        wr(8'h00, 8'h01);
        wr(8'h3f, 8'ha5);
        wr(8'h3f, 8'h01);
        chk("read_kept", 12'h05a, {4'h0, q});
        wr(8'h00, 8'h01);
        chk("read_zero", 12'h000, {4'h0, q});
        wr(8'h02, 8'h01);
        chk("read_unlisted", 12'h000, {4'h0, q});
        wr(8'h00, 8'h00);
        overvoltage_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk("overvoltage", 12'h001, {11'h0, overrange_or_readback_pin});
        $display("Test readback done");
        wr(8'h00, 8'h02);
        chk("soft_reset", 12'h000, {swing_code, gain_select, offset_fix_enable, digital_path_enable});
        chk("soft_boost", 12'h000, {9'h0, performance_boost_one, performance_boost_two});
        $display("Test soft reset done");
        print_verdict();
    end
endmodule : adcsr_regbank_tb_top
`default_nettype wire
